// File: verilog/mbsd_regs.svh
// Purpose: constants for the memory board select decode block
// Assumes: executive bus pins arrive asynchronously to core_clk
// Notes:   offsets and bank map are plain defaults where not fixed
//
// Functional notes
// - decode five ram and four rom selects
// - select eight enables system static ram
// - rom and waveform ram selects are latched
// - latches always driven, transparent while strobe high
// - produce data buffer enable beside selects
// - memories in byte pairs, one select each
// - all memories share one latched address bus
// - buffer passes data only when all enables high
// - io read 8040 returns straps and bank lines
`ifndef MBSD_REGS_SVH
`define MBSD_REGS_SVH

`define MBSD_CFG_ADDR      16'h8040
`define MBSD_ROM_BANK      4'hf
`define MBSD_RAM_BANK      4'h0
`define MBSD_SRAM_SEL      3'h4
`define MBSD_SEL_IDX_W     3
`define MBSD_ROM_FIELD_LSB 14
`define MBSD_STRAP_RST     4'h0
`define MBSD_BANK_LSB      20
`define MBSD_BANK_W        4
`define MBSD_IO_ADDR_W     16
`define MBSD_ROM_IDX_W     2
`define MBSD_ROM_COUNT     4
`define MBSD_RAM_COUNT     5

`endif

// File: verilog/mbsd_pkg.sv
// Purpose: types for the memory board select decode block
// Assumes: nothing beyond the constants header
// Notes:   selects travel together as one struct
package mbsd_pkg;
	typedef struct packed {
		logic [3:0] rom_chip_selects;
		logic [4:0] ram_chip_selects;
	} mbsd_sel_s;

	typedef struct packed {
		logic [3:0] straps;
		logic [3:0] bank;
	} mbsd_cfg_s;
endpackage

// File: verilog/mbsd_decode.sv
// Purpose: address decode, select latching and data buffer control
// Assumes: all pins are synchronised here before use
// Notes:   latch behaviour is modelled on core_clk, three cycles behind pins
`timescale 1ns/10ps
`default_nettype none
`include "mbsd_regs.svh"

module mbsd_decode
	import mbsd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [23:0] exec_addr,
	input  wire logic        address_latch_strobe,
	input  wire logic        mem_req,
	input  wire logic        io_rd,
	input  wire logic        exec_rd,
	input  wire logic [3:0]  config_straps,
	output logic [23:0]      latched_addr,
	output logic [3:0]       rom_chip_selects,
	output logic [4:0]       ram_chip_selects,
	output logic             static_ram_select,
	output logic             buf_enable,
	output logic             buf_dir_to_bus,
	output logic [7:0]       io_rdata,
	output logic             io_rdata_oe
);

	// ************************************
	// input synchronisers
	// ************************************
	logic [23:0] addr_s1_q, addr_s2_q;
	logic [3:0]  ctl_s1_q, ctl_s2_q;
	logic [3:0]  strap_s1_q, strap_s2_q;
	// limitation: the address word crosses without a handshake, so the host must
	// hold it steady for three cycles before the selects are trusted

	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_s1_q  <= 24'h000000;
			addr_s2_q  <= 24'h000000;
			ctl_s1_q   <= 4'h0;
			ctl_s2_q   <= 4'h0;
			strap_s1_q <= `MBSD_STRAP_RST;
			strap_s2_q <= `MBSD_STRAP_RST;
		end else begin
			addr_s1_q  <= exec_addr;
			addr_s2_q  <= addr_s1_q;
			ctl_s1_q   <= {exec_rd, address_latch_strobe, mem_req, io_rd};
			ctl_s2_q   <= ctl_s1_q;
			strap_s1_q <= config_straps;
			strap_s2_q <= strap_s1_q;
		end
	end

	// control pins share one two-stage synchroniser so strobe, request and
	// direction are seen on the same edge
	logic ale, req, iord, rd_sync;
	assign ale     = ctl_s2_q[2];
	assign req     = ctl_s2_q[1];
	assign iord    = ctl_s2_q[0];
	assign rd_sync = ctl_s2_q[3];

	// ************************************
	// select decode
	// ************************************
	// a20-a23 arrive already bank-encoded by the host
	mbsd_sel_s sel_raw;
	logic [3:0] bank;
	logic [1:0] rom_idx;
	logic [2:0] ram_idx;
	assign bank    = addr_s2_q[`MBSD_BANK_LSB +: `MBSD_BANK_W];
	assign rom_idx = addr_s2_q[`MBSD_ROM_FIELD_LSB +: `MBSD_ROM_IDX_W];
	assign ram_idx = addr_s2_q[`MBSD_ROM_FIELD_LSB +: `MBSD_SEL_IDX_W];

	genvar gi;
	generate
		for (gi = 0; gi < `MBSD_ROM_COUNT; gi++) begin : g_rom
			assign sel_raw.rom_chip_selects[gi] = req && (bank == `MBSD_ROM_BANK)
				&& (rom_idx == 2'(gi));
		end
		for (gi = 0; gi < `MBSD_RAM_COUNT; gi++) begin : g_ram
			assign sel_raw.ram_chip_selects[gi] = req && (bank == `MBSD_RAM_BANK)
				&& (ram_idx == 3'(gi));
		end
	endgenerate

	// ************************************
	// select and address latches
	// ************************************
	// transparent while strobe high, holds when low; reset only to park the
	// memories deselected, the board itself never begins a cycle
	// clocked enable registers stand in for the transparent latches; the cost
	// is one cycle of latency against a glitch-free, timing-clean select
	mbsd_sel_s sel_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sel_q <= '0;
		end else if (ale) begin
			sel_q <= sel_raw;
		end
	end // hold otherwise

	always_ff @(posedge core_clk) begin
		if (srst) begin
			latched_addr <= 24'h000000;
		end else if (ale) begin
			latched_addr <= addr_s2_q;
		end
	end

	// one select per high/low byte pair; both bytes share the select
	assign rom_chip_selects  = sel_q.rom_chip_selects;
	assign ram_chip_selects  = sel_q.ram_chip_selects;
	assign static_ram_select = sel_q.ram_chip_selects[`MBSD_SRAM_SEL];

	// ************************************
	// data buffer enable and readback
	// ************************************
	logic any_sel;
	assign any_sel = |sel_q;
	// registered so the buffer opens one edge after the select settles

	always_ff @(posedge core_clk) begin
		if (srst) begin
			buf_enable     <= 1'b0;
			buf_dir_to_bus <= 1'b0;
		end else begin
			buf_enable     <= any_sel && req;
			buf_dir_to_bus <= rd_sync;
		end
	end

	mbsd_cfg_s cfg;
	assign cfg.straps = strap_s2_q;
	assign cfg.bank   = bank;

	// data forced to zero off-address so a stray read never shows the straps
	logic cfg_hit;
	assign cfg_hit = iord && (addr_s2_q[`MBSD_IO_ADDR_W-1:0] == `MBSD_CFG_ADDR);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			io_rdata    <= 8'h00;
			io_rdata_oe <= 1'b0;
		end else begin
			io_rdata_oe <= cfg_hit;
			io_rdata    <= cfg_hit ? cfg : 8'h00;
		end
	end

	// ************************************
	// checks
	// ************************************
	a_sel_hold_low: assert property (@(posedge core_clk) disable iff (srst)
		!ale |=> $stable(sel_q))
		else $error("selects changed while strobe low");
	a_sel_follow: assert property (@(posedge core_clk) disable iff (srst)
		ale |=> sel_q == $past(sel_raw))
		else $error("selects did not follow while strobe high");
	a_sram_map: assert property (@(posedge core_clk) disable iff (srst)
		ale && req && bank == `MBSD_RAM_BANK && ram_idx == `MBSD_SRAM_SEL
			|=> static_ram_select && $onehot(ram_chip_selects))
		else $error("static ram select mismatch");
	a_buf_gate: assert property (@(posedge core_clk) disable iff (srst)
		buf_enable |-> $past(any_sel) && $past(req))
		else $error("buffer enabled without all enables");
	a_buf_on: assert property (@(posedge core_clk) disable iff (srst)
		any_sel && req |=> buf_enable)
		else $error("buffer not enabled");
	a_cfg_read: assert property (@(posedge core_clk) disable iff (srst)
		iord && addr_s2_q[`MBSD_IO_ADDR_W-1:0] == `MBSD_CFG_ADDR
			|=> io_rdata_oe && io_rdata == $past(cfg))
		else $error("config readback wrong");
	a_rom_onehot: assert property (@(posedge core_clk) disable iff (srst)
		$onehot0(sel_raw))
		else $error("more than one select decoded");
	a_addr_hold: assert property (@(posedge core_clk) disable iff (srst)
		!ale |=> $stable(latched_addr))
		else $error("latched address moved while strobe low");

	// ************************************
	// decode, buffer, readback and reset checks
	// ************************************
	// decode checks look one edge past the strobe, where the latch has taken
	// the new selects; the bank compare is repeated here so a broken decoder
	// cannot hide behind its own terms
	a_rom_decode: assert property (@(posedge core_clk) disable iff (srst)
		ale && req && bank == `MBSD_ROM_BANK
			|=> $onehot(rom_chip_selects) && ram_chip_selects == 5'h00)
		else $error("rom bank did not give one rom select");
	a_ram_decode: assert property (@(posedge core_clk) disable iff (srst)
		ale && req && bank == `MBSD_RAM_BANK && ram_idx <= `MBSD_SRAM_SEL
			|=> $onehot(ram_chip_selects) && rom_chip_selects == 4'h0)
		else $error("ram bank did not give one ram select");
	a_ram_beyond: assert property (@(posedge core_clk) disable iff (srst)
		ale && bank == `MBSD_RAM_BANK && ram_idx > `MBSD_SRAM_SEL |=> !any_sel)
		else $error("ram index past select eight decoded");
	a_bank_other: assert property (@(posedge core_clk) disable iff (srst)
		ale && bank != `MBSD_ROM_BANK && bank != `MBSD_RAM_BANK |=> !any_sel)
		else $error("unmapped bank decoded a select");
	a_idle_deselect: assert property (@(posedge core_clk) disable iff (srst)
		ale && !req |=> !any_sel)
		else $error("select decoded without a memory cycle");
	a_pair_onehot: assert property (@(posedge core_clk) disable iff (srst)
		$onehot0(sel_q))
		else $error("two byte pairs selected at once");
	a_addr_follow: assert property (@(posedge core_clk) disable iff (srst)
		ale |=> latched_addr == $past(addr_s2_q))
		else $error("latched address did not follow while strobe high");
	a_buf_off: assert property (@(posedge core_clk) disable iff (srst)
		!req |=> !buf_enable)
		else $error("buffer enabled outside a memory cycle");
	a_dir_follow: assert property (@(posedge core_clk) disable iff (srst)
		1'b1 |=> buf_dir_to_bus == $past(rd_sync))
		else $error("buffer direction did not follow the read line");
	a_cfg_miss: assert property (@(posedge core_clk) disable iff (srst)
		!(iord && addr_s2_q[`MBSD_IO_ADDR_W-1:0] == `MBSD_CFG_ADDR)
			|=> !io_rdata_oe && io_rdata == 8'h00)
		else $error("readback driven outside the config address");
	// no disable here: this one watches the reset itself
	a_reset_park: assert property (@(posedge core_clk)
		srst |=> !any_sel && !buf_enable && !io_rdata_oe && latched_addr == 24'h000000)
		else $error("outputs not parked by reset");

endmodule // mbsd_decode

`default_nettype wire

// File: verification/mbsd_exec_model.sv
// Purpose: executive side bus model
// Assumes: pins change on falling edge
// Notes:   board never starts a cycle
`timescale 1ns/10ps
`default_nettype none
module mbsd_exec_model (
	input  wire logic        core_clk,
	output logic [23:0]      exec_addr,
	output logic             address_latch_strobe,
	output logic             mem_req,
	output logic             io_rd,
	output logic             exec_rd
);
	initial begin
		exec_addr = 24'h0;
		address_latch_strobe = 1'b0;
		mem_req = 1'b0;
		io_rd = 1'b0;
		exec_rd = 1'b0;
	end
	// held five cycles: pins pass two sync stages
	task automatic cyc(input logic [23:0] a, input logic s, m, i);
		@(negedge core_clk);
		exec_addr = a;
		address_latch_strobe = s;
		mem_req = m;
		exec_rd = m;
		io_rd = i;
		repeat (5) @(negedge core_clk);
	endtask
endmodule // mbsd_exec_model
`default_nettype wire

// File: verification/tb_memory_board_select_decode.sv
// Purpose: self-checking bench for the select decode
// Assumes: bank 0 ram, bank f rom
// Notes:   outputs sampled at falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_memory_board_select_decode;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] straps = 4'ha;
	logic [23:0] exec_addr, latched_addr;
	logic als, mreq, iord, erd, sram, buf_en, dir, oe;
	logic [3:0] rom;
	logic [4:0] ram;
	logic [7:0] rdata;
	int errors = 0;
	int checked = 0;
	always #2 core_clk = ~core_clk;
	mbsd_exec_model mbsd_exec_model_i (.core_clk(core_clk), .exec_addr(exec_addr),
		.address_latch_strobe(als), .mem_req(mreq), .io_rd(iord), .exec_rd(erd));
	mbsd_decode mbsd_decode_i (.core_clk(core_clk), .srst(srst), .exec_addr(exec_addr),
		.address_latch_strobe(als), .mem_req(mreq), .io_rd(iord), .exec_rd(erd),
		.config_straps(straps), .latched_addr(latched_addr), .rom_chip_selects(rom),
		.ram_chip_selects(ram), .static_ram_select(sram), .buf_enable(buf_en),
		.buf_dir_to_bus(dir), .io_rdata(rdata), .io_rdata_oe(oe));
	task automatic chk(input string n, input logic [23:0] e, g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_ram;
		logic [23:0] a;
		for (int i = 0; i < 5; i++) begin
			a = {7'h0, 3'(i), 14'h0123};
			mbsd_exec_model_i.cyc(a, 1'b1, 1'b1, 1'b0);
			chk("ram", 24'(5'h1 << i), 24'(ram));
			chk("sram", 24'(i == 4), 24'(sram));
			chk("addr", a, latched_addr);
			chk("buf", 24'h1, 24'(buf_en));
		end
	endtask
	task automatic t_rom;
		for (int i = 0; i < 4; i++) begin
			mbsd_exec_model_i.cyc({8'hf0, 2'(i), 14'h0}, 1'b1, 1'b1, 1'b0);
			chk("rom", 24'({4'(4'h1 << i), 5'h00}), 24'({rom, ram}));
			chk("dir", 24'h1, 24'(dir));
		end
	endtask
	// no select for an unmapped bank, a ram index past eight or an idle cycle
	task automatic t_nodecode;
		mbsd_exec_model_i.cyc(24'h500000, 1'b1, 1'b1, 1'b0);
		chk("nobank", 24'h0, 24'({rom, ram}));
		chk("nobuf", 24'h0, 24'(buf_en));
		mbsd_exec_model_i.cyc(24'h01c000, 1'b1, 1'b1, 1'b0);
		chk("noidx", 24'h0, 24'({rom, ram}));
		mbsd_exec_model_i.cyc(24'h010000, 1'b1, 1'b0, 1'b0);
		chk("noreq", 24'h0, 24'({rom, ram, sram}));
	endtask
	// strobe low must freeze selects across a new address
	task automatic t_hold;
		mbsd_exec_model_i.cyc(24'h010000, 1'b1, 1'b1, 1'b0);
		mbsd_exec_model_i.cyc(24'hf04000, 1'b0, 1'b1, 1'b0);
		chk("hold", 24'h010, 24'({rom, ram}));
		chk("haddr", 24'h010000, latched_addr);
	endtask
	task automatic t_cfg;
		mbsd_exec_model_i.cyc(24'h308040, 1'b0, 1'b0, 1'b1);
		chk("cfg", 24'h1a3, 24'({oe, rdata}));
		chk("bufoff", 24'h0, 24'(buf_en));
		chk("dir0", 24'h0, 24'(dir));
		mbsd_exec_model_i.cyc(24'h308041, 1'b0, 1'b0, 1'b1);
		chk("cfgmiss", 24'h0, 24'({oe, rdata}));
		@(negedge core_clk);
		straps = 4'h5;
		mbsd_exec_model_i.cyc(24'hc08040, 1'b0, 1'b0, 1'b1);
		chk("cfg2", 24'h15c, 24'({oe, rdata}));
	endtask
	// mid-run reset parks every output while the pins still hold a config read
	task automatic t_reset;
		@(negedge core_clk);
		srst = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("rstsel", 24'h0, 24'({rom, ram, sram, buf_en, dir}));
		chk("rstaddr", 24'h0, latched_addr);
		chk("rstcfg", 24'h0, 24'({oe, rdata}));
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		chk("rstback", 24'h15c, 24'({oe, rdata}));
	endtask
	initial begin
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		repeat (3) @(negedge core_clk);
		t_ram();
		t_rom();
		t_nodecode();
		t_hold();
		t_cfg();
		t_reset();
		tally_and_finish();
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule // tb_memory_board_select_decode
`default_nettype wire
